// file: pkg/usb_hc_regs_pkg.sv
package usb_hc_regs_pkg;

	// ----------------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------------
	localparam logic [7:0] OFS_COMMAND_REQUEST      = 8'h08;
	localparam logic [7:0] OFS_OVERRUN_COUNT_STATUS = 8'h0A;
	localparam logic [7:0] OFS_EVENT_FLAGS          = 8'h0C;
	localparam logic [7:0] OFS_OWNERSHIP_FLAGS      = 8'h0E;
	localparam logic [7:0] OFS_EVENT_ENABLES        = 8'h10;

	// ----------------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------------
	localparam int CMD_CONTROLLER_RESET_BIT = 0;
	localparam int CMD_CTRL_LIST_FILLED_BIT = 1;
	localparam int CMD_BULK_LIST_FILLED_BIT = 2;
	localparam int CMD_OWNER_CHANGE_REQ_BIT = 3;
	localparam int OWN_CHANGE_BIT           = 14;

	// Event flag and enable bit positions, shared by both registers.
	localparam int EV_SCHED_OVERRUN  = 0;
	localparam int EV_DONE_HEAD      = 1;
	localparam int EV_FRAME_START    = 2;
	localparam int EV_RESUME_SEEN    = 3;
	localparam int EV_FATAL_ERROR    = 4;
	localparam int EV_FRAME_OVERFLOW = 5;
	localparam int EV_ROOTHUB_CHANGE = 6;
	localparam int EV_COUNT          = 7;

	// Writable event bits: the fatal error position stays zero.
	localparam logic [6:0] EV_IMPL_MASK = 7'h6F;

	// ----------------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------------
	localparam logic [3:0]  RST_COMMAND  = 4'h0;
	localparam logic [1:0]  RST_OVERRUN  = 2'h0;
	localparam logic [6:0]  RST_EVENTS   = 7'h00;
	localparam logic [15:0] RST_RDATA    = 16'h0000;

endpackage

// file: hdl/sticky_flag_bank.sv
`timescale 1ns/100ps

// Bank of sticky flags: hardware sets, software clears by writing one.
module sticky_flag_bank #(
	parameter int WIDTH = 7
) (
	input  wire logic             mclk_i,    // Controller clock.
	input  wire logic             resetn_i,  // Synchronous reset, active low.
	input  wire logic [WIDTH-1:0] set_i,     // Per-flag set pulses.
	input  wire logic [WIDTH-1:0] clr_i,     // Per-flag clear strobes.
	input  wire logic [WIDTH-1:0] impl_i,    // Flags that exist; others stay zero.
	output logic      [WIDTH-1:0] flags_o    // Current flag values.
);

	logic [WIDTH-1:0] flag_q;
	logic [WIDTH-1:0] flag_d;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_flag
			// A set arriving with the clear wins, so no event is lost.
			always_comb begin
				flag_d[i] = flag_q[i];
				if (clr_i[i]) begin
					flag_d[i] = 1'b0;
				end
				if (set_i[i]) begin
					flag_d[i] = 1'b1;
				end
				if (!impl_i[i]) begin
					flag_d[i] = 1'b0;
				end
			end

			always_ff @(posedge mclk_i) begin
				if (!resetn_i) begin
					flag_q[i] <= 1'b0;
				end else begin
					flag_q[i] <= flag_d[i];
				end
			end
		end
	endgenerate

	assign flags_o = flag_q;

endmodule

// file: hdl/usb_host_cmd_irq_status_regs.sv
`timescale 1ns/100ps

// Functional notes
// - Writing one to owner_change_req sets the ownership change flag.
// - Bulk list filled clears when bulk list head processing starts, unless set or written in that cycle.
// - Bulk list filled, set by software or hardware, means active descriptors.
// - Control list filled clears when control list head processing starts, unless set or written in that cycle.
// - Control list filled, set by software or hardware, means active descriptors.
// - Writing controller reset starts reset; bit clears when reset completes.
// - Two-bit overrun counter counts each scheduling overrun, wrapping 3 to 0.
// - Root hub change flag sets on any root hub or port status change.
// - Frame overflow flag sets when frame counter MSB toggles either way.
// - Resume flag sets when resume signaling is seen downstream.
// - Frame start flag sets on each frame start event.
// - Done head flag sets after done head written to shared area.
// - Scheduling overrun flag sets when list processor reports overrun.
// - Fatal error flag and enable are absent and read zero.
// - Ownership change bit sets while owner change request bit is set.
// - Each enable lets its event flag raise an interrupt; zero ignores it.
// - Reserved upper bits of command and status registers read zero.
// - Routing select sends interrupt to normal line or management interrupt.
module usb_host_cmd_irq_status_regs (
	input  wire logic        mclk_i,               // Controller clock, 100 MHz.
	input  wire logic        resetn_i,             // Synchronous reset, active low.
	input  wire logic [7:0]  reg_addr_i,           // Register byte offset.
	input  wire logic        reg_wr_i,             // Write strobe.
	input  wire logic        reg_rd_i,             // Read strobe.
	input  wire logic [1:0]  reg_be_i,             // Byte enables of the 16-bit lane.
	input  wire logic [15:0] reg_wdata_i,          // Write data.
	output logic      [15:0] reg_rdata_o,          // Read data, one cycle after strobe.
	output logic             reg_rvalid_o,         // Read data valid pulse.
	input  wire logic        bulk_head_start_i,    // List processor begins bulk head.
	input  wire logic        ctrl_head_start_i,    // List processor begins control head.
	input  wire logic        bulk_fill_set_i,      // List processor marks bulk list filled.
	input  wire logic        ctrl_fill_set_i,      // List processor marks control list filled.
	input  wire logic        reset_done_i,         // Controller reset operation complete.
	input  wire logic        roothub_change_i,     // Root hub or port status changed.
	input  wire logic        frame_counter_msb_i,  // Frame counter bit 15.
	input  wire logic        resume_seen_i,        // Resume signaling on a port.
	input  wire logic        frame_start_i,        // Frame start event.
	input  wire logic        done_head_written_i,  // Done list pointer written out.
	input  wire logic        sched_overrun_i,      // Schedule overrun reported.
	input  wire logic        irq_routing_sel_i,    // 0 normal interrupt, 1 management.
	output logic             bulk_list_filled_o,   // Bulk list has active descriptors.
	output logic             ctrl_list_filled_o,   // Control list has active descriptors.
	output logic             controller_reset_req_o, // Reset operation requested.
	output logic             owner_change_req_o,   // Ownership change requested.
	output logic             irq_o,                // Normal interrupt, active high.
	output logic             smi_o                 // Management interrupt, active high.
);

	// ----------------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------------
	logic wr_cmd;
	logic wr_ovr;
	logic wr_evf;
	logic wr_own_hi;
	logic wr_ena;

	// Eight-bit registers live in the low lane, so only byte enable zero opens
	// them; the ownership flag sits in the high lane and needs byte enable one.
	assign wr_cmd    = reg_wr_i && reg_be_i[0] && (reg_addr_i == usb_hc_regs_pkg::OFS_COMMAND_REQUEST);
	assign wr_ovr    = reg_wr_i && reg_be_i[0] && (reg_addr_i == usb_hc_regs_pkg::OFS_OVERRUN_COUNT_STATUS);
	assign wr_evf    = reg_wr_i && reg_be_i[0] && (reg_addr_i == usb_hc_regs_pkg::OFS_EVENT_FLAGS);
	assign wr_own_hi = reg_wr_i && reg_be_i[1] && (reg_addr_i == usb_hc_regs_pkg::OFS_OWNERSHIP_FLAGS);
	assign wr_ena    = reg_wr_i && reg_be_i[0] && (reg_addr_i == usb_hc_regs_pkg::OFS_EVENT_ENABLES);

	// ----------------------------------------------------------------------
	// Command request bits
	// ----------------------------------------------------------------------
	logic [3:0] cmd_q;
	logic [3:0] cmd_d;

	// Later assignments win: a write or a hardware set beats a hardware clear
	// in the same cycle, so a freshly queued descriptor is never forgotten.
	always_comb begin
		cmd_d = cmd_q;
		if (reset_done_i) begin
			cmd_d[usb_hc_regs_pkg::CMD_CONTROLLER_RESET_BIT] = 1'b0;
		end
		if (bulk_head_start_i) begin
			cmd_d[usb_hc_regs_pkg::CMD_BULK_LIST_FILLED_BIT] = 1'b0;
		end
		if (ctrl_head_start_i) begin
			cmd_d[usb_hc_regs_pkg::CMD_CTRL_LIST_FILLED_BIT] = 1'b0;
		end
		if (wr_cmd) begin
			cmd_d = reg_wdata_i[3:0];
		end
		if (wr_cmd && reg_wdata_i[usb_hc_regs_pkg::CMD_CONTROLLER_RESET_BIT]) begin
			cmd_d[usb_hc_regs_pkg::CMD_CONTROLLER_RESET_BIT] = 1'b1;
		end
		if (bulk_fill_set_i) begin
			cmd_d[usb_hc_regs_pkg::CMD_BULK_LIST_FILLED_BIT] = 1'b1;
		end
		if (ctrl_fill_set_i) begin
			cmd_d[usb_hc_regs_pkg::CMD_CTRL_LIST_FILLED_BIT] = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			cmd_q <= usb_hc_regs_pkg::RST_COMMAND;
		end else begin
			cmd_q <= cmd_d;
		end
	end

	// ----------------------------------------------------------------------
	// Event sources and overrun counter
	// ----------------------------------------------------------------------
	logic       msb_prev_q;
	logic       msb_prev_d;
	logic       msb_valid_q;
	logic       msb_valid_d;
	logic [1:0] ovr_cnt_q;
	logic [1:0] ovr_cnt_d;
	logic [6:0] ev_set;
	logic [6:0] ev_clr;

	always_comb begin
		msb_prev_d  = frame_counter_msb_i;
		msb_valid_d = 1'b1;
		ovr_cnt_d   = ovr_cnt_q;
		if (wr_ovr) begin
			ovr_cnt_d = reg_wdata_i[1:0];
		end
		// An overrun in the same cycle as a write still counts, at the cost of
		// the written value being dropped for that cycle.
		// count and wrap
		if (sched_overrun_i) begin
			ovr_cnt_d = ovr_cnt_q + 2'h1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			msb_prev_q  <= 1'b0;
			msb_valid_q <= 1'b0;
			ovr_cnt_q   <= usb_hc_regs_pkg::RST_OVERRUN;
		end else begin
			msb_prev_q  <= msb_prev_d;
			msb_valid_q <= msb_valid_d;
			ovr_cnt_q   <= ovr_cnt_d;
		end
	end

	always_comb begin
		ev_set = 7'h00;
		ev_set[usb_hc_regs_pkg::EV_SCHED_OVERRUN]  = sched_overrun_i;
		ev_set[usb_hc_regs_pkg::EV_DONE_HEAD]      = done_head_written_i;
		ev_set[usb_hc_regs_pkg::EV_FRAME_START]    = frame_start_i;
		ev_set[usb_hc_regs_pkg::EV_RESUME_SEEN]    = resume_seen_i;
		// The first cycle after reset has no valid previous level, so a frame
		// counter that starts high does not raise a false overflow.
		// MSB toggle either way
		ev_set[usb_hc_regs_pkg::EV_FRAME_OVERFLOW] = msb_valid_q && (frame_counter_msb_i != msb_prev_q);
		ev_set[usb_hc_regs_pkg::EV_ROOTHUB_CHANGE] = roothub_change_i;
		ev_clr = wr_evf ? reg_wdata_i[6:0] : 7'h00;
	end

	// The flag bank forces unimplemented positions to zero on every cycle,
	// so neither a set pulse nor a stray write can make them appear.
	// fatal error kept zero
	logic [6:0] ev_flags;

	sticky_flag_bank #(
		.WIDTH(usb_hc_regs_pkg::EV_COUNT)
	) u_event_flags (
		.mclk_i  (mclk_i),
		.resetn_i(resetn_i),
		.set_i   (ev_set),
		.clr_i   (ev_clr),
		.impl_i  (usb_hc_regs_pkg::EV_IMPL_MASK),
		.flags_o (ev_flags)
	);

	// ----------------------------------------------------------------------
	// Ownership change flag and event enables
	// ----------------------------------------------------------------------
	logic       own_chg_q;
	logic       own_chg_d;
	logic [6:0] ena_q;
	logic [6:0] ena_d;

	always_comb begin
		own_chg_d = own_chg_q;
		if (wr_own_hi && reg_wdata_i[usb_hc_regs_pkg::OWN_CHANGE_BIT]) begin
			own_chg_d = 1'b0;
		end
		// The set comes last, so the flag cannot be cleared while the request
		// bit stays high; software must drop the request first.
		// request sets flag
		if (cmd_q[usb_hc_regs_pkg::CMD_OWNER_CHANGE_REQ_BIT]) begin
			own_chg_d = 1'b1;
		end
		ena_d = ena_q;
		if (wr_ena) begin
			ena_d = reg_wdata_i[6:0] & usb_hc_regs_pkg::EV_IMPL_MASK;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			own_chg_q <= 1'b0;
			ena_q     <= usb_hc_regs_pkg::RST_EVENTS;
		end else begin
			own_chg_q <= own_chg_d;
			ena_q     <= ena_d;
		end
	end

	// ----------------------------------------------------------------------
	// Interrupt outputs
	// ----------------------------------------------------------------------
	logic irq_q;
	logic irq_d;
	logic smi_q;
	logic smi_d;
	logic pend;

	// Both lines are registered, so an interrupt follows its flag by one cycle
	// and the routing select is taken on the same edge as the flags.
	always_comb begin
		pend  = |(ev_flags & ena_q);
		irq_d = pend && !irq_routing_sel_i;
		smi_d = pend && irq_routing_sel_i;
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			irq_q <= 1'b0;
			smi_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
			smi_q <= smi_d;
		end
	end

	// ----------------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------------
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic        rvalid_q;
	logic        rvalid_d;

	// Read data is zero outside a read, so a master that looks at the data
	// without the valid pulse sees nothing stale.
	always_comb begin
		rvalid_d = reg_rd_i;
		rdata_d  = usb_hc_regs_pkg::RST_RDATA;
		if (reg_rd_i) begin
			case (reg_addr_i)
				usb_hc_regs_pkg::OFS_COMMAND_REQUEST:      rdata_d = {12'h000, cmd_q};
				usb_hc_regs_pkg::OFS_OVERRUN_COUNT_STATUS: rdata_d = {14'h0000, ovr_cnt_q};
				usb_hc_regs_pkg::OFS_EVENT_FLAGS:          rdata_d = {9'h000, ev_flags};
				usb_hc_regs_pkg::OFS_OWNERSHIP_FLAGS:      rdata_d = {1'b0, own_chg_q, 14'h0000};
				usb_hc_regs_pkg::OFS_EVENT_ENABLES:        rdata_d = {9'h000, ena_q};
				default:                                   rdata_d = usb_hc_regs_pkg::RST_RDATA;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rdata_q  <= usb_hc_regs_pkg::RST_RDATA;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// Outputs straight from flip-flops.
	assign reg_rdata_o            = rdata_q;
	assign reg_rvalid_o           = rvalid_q;
	assign bulk_list_filled_o     = cmd_q[usb_hc_regs_pkg::CMD_BULK_LIST_FILLED_BIT];
	assign ctrl_list_filled_o     = cmd_q[usb_hc_regs_pkg::CMD_CTRL_LIST_FILLED_BIT];
	assign controller_reset_req_o = cmd_q[usb_hc_regs_pkg::CMD_CONTROLLER_RESET_BIT];
	assign owner_change_req_o     = cmd_q[usb_hc_regs_pkg::CMD_OWNER_CHANGE_REQ_BIT];
	assign irq_o                  = irq_q;
	assign smi_o                  = smi_q;

endmodule

// file: tb/usb_host_cmd_irq_status_regs_assertions.sv
`timescale 1ns/100ps

module usb_hc_regs_chk (
	input wire logic        mclk_i,                 // Clock.
	input wire logic        resetn_i,               // Reset.
	input wire logic [7:0]  reg_addr_i,             // Offset.
	input wire logic        reg_wr_i,               // Write.
	input wire logic        reg_rd_i,               // Read.
	input wire logic [1:0]  reg_be_i,               // Lanes.
	input wire logic [15:0] reg_wdata_i,            // Data in.
	input wire logic [15:0] reg_rdata_o,            // Data out.
	input wire logic        bulk_head_start_i,      // Bulk head.
	input wire logic        ctrl_head_start_i,      // Ctrl head.
	input wire logic        bulk_fill_set_i,        // Bulk fill.
	input wire logic        ctrl_fill_set_i,        // Ctrl fill.
	input wire logic        irq_routing_sel_i,      // Route.
	input wire logic        bulk_list_filled_o,     // Bulk flag.
	input wire logic        ctrl_list_filled_o,     // Ctrl flag.
	input wire logic        controller_reset_req_o, // Reset req.
	input wire logic        owner_change_req_o,     // Owner req.
	input wire logic        irq_o,                  // Irq.
	input wire logic        smi_o                   // Smi.
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);

	wire cmd_wr = reg_wr_i && reg_be_i[0] && reg_addr_i == usb_hc_regs_pkg::OFS_COMMAND_REQUEST;
	wire own_rd = reg_rd_i && reg_addr_i == usb_hc_regs_pkg::OFS_OWNERSHIP_FLAGS;

	// The flag lags the request by a cycle, so only a request already held can be relied on.
	sequence own_held;
		owner_change_req_o ##1 owner_change_req_o && own_rd;
	endsequence

	rsvd_zero_a: assert property (reg_rd_i && reg_addr_i == usb_hc_regs_pkg::OFS_COMMAND_REQUEST
		|=> reg_rdata_o[15:4] == 12'h000) else $error("command read shows reserved bits set");
	bulk_clear_a: assert property (bulk_head_start_i && !bulk_fill_set_i && !cmd_wr |=> !bulk_list_filled_o)
		else $error("bulk filled not cleared at head start");
	ctrl_clear_a: assert property (ctrl_head_start_i && !ctrl_fill_set_i && !cmd_wr |=> !ctrl_list_filled_o)
		else $error("control filled not cleared at head start");
	bulk_set_a: assert property (bulk_fill_set_i |=> bulk_list_filled_o)
		else $error("bulk filled not set");
	ctrl_set_a: assert property (ctrl_fill_set_i |=> ctrl_list_filled_o)
		else $error("control filled not set");
	cmd_write_a: assert property (cmd_wr |=> controller_reset_req_o == $past(reg_wdata_i[0])
		&& owner_change_req_o == $past(reg_wdata_i[3])) else $error("command bits do not follow write");
	owner_hold_a: assert property (!cmd_wr |=> $stable(owner_change_req_o))
		else $error("ownership request changed without a write");
	irq_route_a: assert property (irq_o || smi_o |-> smi_o != irq_o && smi_o == $past(irq_routing_sel_i))
		else $error("interrupt on wrong line");
	owner_flag_a: assert property (own_held |=> reg_rdata_o[14])
		else $error("ownership change flag not set");
endmodule

bind usb_host_cmd_irq_status_regs usb_hc_regs_chk usb_hc_regs_chk_i (.*);

// file: tb/usb_host_cmd_irq_status_regs_tb.sv
`timescale 1ns/100ps

module usb_host_cmd_irq_status_regs_tb;
	logic        mclk_i, resetn_i, reg_wr_i, reg_rd_i, reg_rvalid_o, irq_routing_sel_i, spare;
	logic [7:0]  reg_addr_i;
	logic [1:0]  reg_be_i;
	logic [15:0] reg_wdata_i, reg_rdata_o;
	logic        bulk_head_start_i, ctrl_head_start_i, bulk_fill_set_i, ctrl_fill_set_i, reset_done_i;
	logic        roothub_change_i, frame_counter_msb_i, resume_seen_i, frame_start_i, done_head_written_i;
	logic        sched_overrun_i, bulk_list_filled_o, ctrl_list_filled_o, controller_reset_req_o;
	logic        owner_change_req_o, irq_o, smi_o;
	logic [15:0] exp_q[$];
	logic [6:0]  en;
	int          fail_count, compares, n;

	usb_host_cmd_irq_status_regs usb_host_cmd_irq_status_regs_i (.*);

	initial begin
		mclk_i = 1'h0;
		forever #5 mclk_i = ~mclk_i;
	end

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic summarize();
		if (exp_q.size() != 0)
			fail_count++;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic bad(input string s);
		fail_count++;
		$display("mismatch at %0t: %s", $time, s);
	endtask

	task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
			bad($sformatf("read %h expected %h", got, exp));
	endtask

	task automatic chk_pin(input logic got, input logic exp);
		compares++;
		if (got !== exp)
			bad("output pin level");
	endtask

	// Every read note is matched against the next data pulse in order.
	always @(posedge mclk_i) begin
		#1;
		if (reg_rvalid_o === 1'h1) begin
			if (exp_q.size() == 0)
				bad("unexpected read data");
			else
				chk_rd(reg_rdata_o, exp_q.pop_front());
		end
	end

	// ----------------------------------------
	// Drivers, all changing at the falling edge
	// ----------------------------------------
	task automatic drive(input logic [11:0] v);
		{bulk_head_start_i, ctrl_head_start_i, bulk_fill_set_i, ctrl_fill_set_i, reset_done_i, roothub_change_i,
			frame_counter_msb_i, spare, resume_seen_i, frame_start_i, done_head_written_i, sched_overrun_i} = v;
	endtask

	task automatic pulse(input logic [11:0] v);
		@(negedge mclk_i);
		drive(v);
		@(negedge mclk_i);
		drive(12'h000);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge mclk_i);
		{reg_addr_i, reg_be_i, reg_wdata_i, reg_wr_i} = {a, 2'h3, d, 1'h1};
		@(negedge mclk_i);
		reg_wr_i = 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(negedge mclk_i);
		{reg_addr_i, reg_rd_i} = {a, 1'h1};
		exp_q.push_back(e);
		@(negedge mclk_i);
		reg_rd_i = 1'h0;
	endtask

	initial begin
		repeat (20000) @(posedge mclk_i);
		bad("run did not finish");
		summarize();
	end

	initial begin
		fail_count = 0;
		compares = 0;
		resetn_i = 1'h0;
		{reg_wr_i, reg_rd_i, reg_addr_i, reg_be_i, reg_wdata_i, irq_routing_sel_i} = '0;
		drive(12'h000);
		void'($urandom(32'hA1F00A3A));
		repeat (16) @(negedge mclk_i);
		resetn_i = 1'h1;
		for (int a = 8; a <= 18; a += 2)
			rd(8'(a), 16'h0000);
		wr(8'h08, 16'hFFFF);
		rd(8'h08, 16'h000F);
		chk_pin(controller_reset_req_o, 1'h1);
		pulse(12'hC80);
		rd(8'h08, 16'h0008);
		pulse(12'h300);
		rd(8'h08, 16'h000E);
		chk_pin(bulk_list_filled_o, 1'h1);
		chk_pin(ctrl_list_filled_o, 1'h1);
		wr(8'h0E, 16'h4000);
		rd(8'h0E, 16'h4000);
		wr(8'h08, 16'h0000);
		chk_pin(owner_change_req_o, 1'h0);
		wr(8'h0E, 16'h4000);
		rd(8'h0E, 16'h0000);
		wr(8'h10, 16'hFFFF);
		rd(8'h10, 16'h006F);
		for (int i = 0; i < 7; i++) begin
			if (i == 4)
				continue;
			pulse(12'(1 << i));
			wr(8'h0C, 16'h0000);
			rd(8'h0C, 16'(1 << i));
			chk_pin(irq_o, 1'h1);
			chk_pin(smi_o, 1'h0);
			wr(8'h0C, 16'(1 << i));
			rd(8'h0C, 16'h0000);
			chk_pin(irq_o, 1'h0);
		end
		rd(8'h0A, 16'h0001);
		wr(8'h0A, 16'hFFFF);
		rd(8'h0A, 16'h0003);
		pulse(12'h001);
		rd(8'h0A, 16'h0000);
		n = $urandom_range(9, 1);
		repeat (n) pulse(12'h001);
		rd(8'h0A, 16'(n % 4));
		wr(8'h0C, 16'h007F);
		en = 7'($urandom);
		wr(8'h10, {9'h000, en});
		pulse(12'h06F);
		rd(8'h0C, 16'h006F);
		chk_pin(irq_o, |(en & 7'h6F));
		@(negedge mclk_i);
		irq_routing_sel_i = 1'h1;
		@(negedge mclk_i);
		chk_pin(smi_o, |(en & 7'h6F));
		chk_pin(irq_o, 1'h0);
		wr(8'h10, 16'h0000);
		@(negedge mclk_i);
		chk_pin(smi_o, 1'h0);
		wr(8'h08, 16'h000F);
		@(negedge mclk_i);
		resetn_i = 1'h0;
		repeat (2) @(negedge mclk_i);
		resetn_i = 1'h1;
		rd(8'h08, 16'h0000);
		rd(8'h0C, 16'h0000);
		chk_pin(smi_o, 1'h0);
		summarize();
	end
endmodule
